// ==== rtl/pie_pkg.sv ====
// Purpose: constants for the peripheral interrupt mask bank
// Assumes: apb slave, 32-bit data, one aligned word per register
// Notes on behaviour
// R01: bit 7 set lets clock-fail events request interrupt, clear blocks it
// R02: bit 5 set lets comparator output change raise interrupt, clear blocks
// R03: bit 4 set lets nvm write completion raise interrupt, clear blocks
// R04: bit 3 set lets serial bus collision raise interrupt, clear blocks
// R05: bits 6 and 2..0 read zero, writes to them ignored
// R06: request is pending flag and mask; mask never alters flag
package pie_pkg;
  localparam logic [11:0] MASK_OFS    = 12'h000;
  localparam logic [11:0] STATUS_OFS  = 12'h004;
  localparam logic [11:0] IRQMASK_OFS = 12'h008;
  localparam logic [11:0] REQ_OFS     = 12'h00c;
  localparam int          CLK_FAIL_BIT   = 7;
  localparam int          COMP_BIT       = 5;
  localparam int          NVM_DONE_BIT   = 4;
  localparam int          BUS_COLL_BIT   = 3;
  localparam logic [7:0]  IMPL_BITS      = 8'hb8;
  localparam logic [7:0]  MASK_RESET     = 8'h00;
  localparam logic [7:0]  STATUS_RESET   = 8'h00;
  localparam logic [7:0]  IRQMASK_RESET  = 8'h00;
endpackage : pie_pkg

// ==== rtl/pie_sync.sv ====
// Purpose: two-flop synchroniser for the flag inputs
// Assumes: flags may come from other clock domains
// Notes: first stage feeds only the second stage
module pie_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : pie_sync

// ==== rtl/pie_top.sv ====
// Purpose: peripheral interrupt mask bank with apb access
// Assumes: pending flags kept by the sources, one level per source
// Notes: requests are registered, one cycle after synchronised flags
module pie_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        clock_fail_flag,
  input  wire logic        comparator_flag,
  input  wire logic        nvm_write_done_flag,
  input  wire logic        serial_bus_collision_flag,
  output logic             clock_fail_req,
  output logic             comparator_req,
  output logic             nvm_write_done_req,
  output logic             serial_bus_collision_req,
  output logic             irq
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] flag_in;
  logic [7:0] flag_sync;
  logic [7:0] mask_reg;
  logic [7:0] status_reg;
  logic [7:0] status_prev_reg;
  logic [7:0] irqmask_reg;
  logic [7:0] req_reg;

  assign flag_in = {clock_fail_flag, 1'b0, comparator_flag, nvm_write_done_flag,
                    serial_bus_collision_flag, 3'b000};

  pie_sync #(.W(8)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (flag_in),
    .q   (flag_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // write lands on the completing edge only, so a w1c clear acts once
  wire        wr_en     = psel && penable && pready && pwrite && pstrb[0];
  wire        acc       = psel && penable;
  wire        hit_mask  = paddr == pie_pkg::MASK_OFS;
  wire        hit_stat  = paddr == pie_pkg::STATUS_OFS;
  wire        hit_imask = paddr == pie_pkg::IRQMASK_OFS;
  wire        hit_req   = paddr == pie_pkg::REQ_OFS;
  wire        mapped    = hit_mask || hit_stat || hit_imask || hit_req;
  // R05 unused bits dropped
  wire [7:0]  wdata_impl = pwdata[7:0] & pie_pkg::IMPL_BITS;
  // R06 flag and mask
  wire [7:0]  req_next   = flag_sync & mask_reg;
  // rising edge of a request is the sticky event
  wire [7:0]  rise       = req_next & ~status_prev_reg;
  wire [7:0]  clr        = (wr_en && hit_stat) ? wdata_impl : 8'h00;
  // set wins over clear in the same cycle
  wire [7:0]  status_next = (status_reg & ~clr) | rise;
  wire [7:0]  rd_mux = hit_mask  ? mask_reg :
                       hit_stat  ? status_reg :
                       hit_imask ? irqmask_reg :
                       hit_req   ? req_reg : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // R01 R02 R03 R04 mask register write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_reg    <= pie_pkg::MASK_RESET;
      irqmask_reg <= pie_pkg::IRQMASK_RESET;
    end else begin
      if (wr_en && hit_mask) begin
        mask_reg <= wdata_impl;
      end
      if (wr_en && hit_imask) begin
        irqmask_reg <= wdata_impl;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_reg      <= pie_pkg::STATUS_RESET;
      status_prev_reg <= 8'h00;
      req_reg         <= 8'h00;
      irq             <= 1'b0;
    end else begin
      status_reg      <= status_next;
      status_prev_reg <= req_next;
      req_reg         <= req_next;
      irq             <= |(status_next & irqmask_reg);
    end
  end

  // R01 R02 R03 R04 per-source requests
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_fail_req           <= 1'b0;
      comparator_req           <= 1'b0;
      nvm_write_done_req       <= 1'b0;
      serial_bus_collision_req <= 1'b0;
    end else begin
      clock_fail_req           <= req_next[pie_pkg::CLK_FAIL_BIT];
      comparator_req           <= req_next[pie_pkg::COMP_BIT];
      nvm_write_done_req       <= req_next[pie_pkg::NVM_DONE_BIT];
      serial_bus_collision_req <= req_next[pie_pkg::BUS_COLL_BIT];
    end
  end

  // single wait state: answer in the first access cycle's next edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc && !pready;
      pslverr <= acc && !pready && !mapped;
      prdata  <= (acc && !pready && !pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_clock_fail;
    @(posedge clk) disable iff (rst)
      clock_fail_req == $past(flag_sync[7] & mask_reg[7]);
  endproperty
  a_clock_fail: assert property (p_clock_fail) else $error("clock fail req wrong"); // R01

  property p_comp;
    @(posedge clk) disable iff (rst)
      !mask_reg[5] |=> !comparator_req;
  endproperty
  a_comp: assert property (p_comp) else $error("comparator req not blocked"); // R02

  property p_nvm;
    @(posedge clk) disable iff (rst)
      (flag_sync[4] && mask_reg[4]) |=> nvm_write_done_req;
  endproperty
  a_nvm: assert property (p_nvm) else $error("nvm done req missing"); // R03

  property p_coll;
    @(posedge clk) disable iff (rst)
      serial_bus_collision_req |-> $past(mask_reg[3]) && $past(flag_sync[3]);
  endproperty
  a_coll: assert property (p_coll) else $error("collision req without cause"); // R04

  property p_unused;
    @(posedge clk) disable iff (rst)
      ((mask_reg | irqmask_reg | status_reg) & ~pie_pkg::IMPL_BITS) == 8'h00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit set"); // R05

  property p_rdzero;
    @(posedge clk) disable iff (rst)
      pready |-> prdata[31:8] == 24'h00_0000 && prdata[6] == 1'b0 && prdata[2:0] == 3'b000;
  endproperty
  a_rdzero: assert property (p_rdzero) else $error("unused bit read nonzero"); // R05

  property p_mask_write;
    @(posedge clk) disable iff (rst)
      (wr_en && hit_mask) |=> mask_reg == $past(wdata_impl);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost"); // R01

  property p_sticky;
    @(posedge clk) disable iff (rst)
      rise[7] |=> status_reg[7];
  endproperty
  a_sticky: assert property (p_sticky) else $error("event lost in status"); // R06

  property p_irq;
    @(posedge clk) disable iff (rst)
      ##1 irq == |($past(status_next) & $past(irqmask_reg));
  endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong"); // R06

  property p_clock_block;
    @(posedge clk) disable iff (rst)
      !mask_reg[7] |=> !clock_fail_req;
  endproperty
  a_clock_block: assert property (p_clock_block) else $error("clock fail req not blocked"); // R01

  property p_comp_open;
    @(posedge clk) disable iff (rst)
      (flag_sync[5] && mask_reg[5]) |=> comparator_req;
  endproperty
  a_comp_open: assert property (p_comp_open) else $error("comparator req missing"); // R02

  property p_nvm_block;
    @(posedge clk) disable iff (rst)
      !mask_reg[4] |=> !nvm_write_done_req;
  endproperty
  a_nvm_block: assert property (p_nvm_block) else $error("nvm done req not blocked"); // R03

  property p_coll_block;
    @(posedge clk) disable iff (rst)
      !mask_reg[3] |=> !serial_bus_collision_req;
  endproperty
  a_coll_block: assert property (p_coll_block) else $error("collision req not blocked"); // R04

  property p_status_hold;
    @(posedge clk) disable iff (rst)
      (|($past(status_reg) & ~status_reg)) |-> $past(wr_en && hit_stat);
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status bit lost without clear"); // R06

  property p_irq_level;
    @(posedge clk) disable iff (rst)
      (irqmask_reg == $past(irqmask_reg)) |-> irq == |(status_reg & irqmask_reg);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not following status"); // R06

  property p_pready_pulse;
    @(posedge clk) disable iff (rst)
      pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready longer than one cycle");

  property p_slverr_pready;
    @(posedge clk) disable iff (rst)
      pslverr |-> pready;
  endproperty
  a_slverr_pready: assert property (p_slverr_pready) else $error("pslverr without pready");
endmodule : pie_top

// ==== testbench/pie_src.sv ====
// Purpose: pending flag sources at the far side of the mask bank
// Assumes: bench pulses set and clear commands one cycle wide
// Notes: a flag stays set until its source clears it
module pie_src (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] set_cmd,
  input  wire logic [3:0] clr_cmd,
  output logic      [3:0] flags
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) flags <= 4'h0;
    else flags <= (flags | set_cmd) & ~clr_cmd;
  end
endmodule : pie_src

// ==== testbench/tb_pie_top.sv ====
// Purpose: self-checking bench for the interrupt mask bank
// Assumes: apb master tasks, one flag source model
// Notes: fixed waits cover the three-edge flag path
module tb_pie_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb, set_cmd, clr_cmd, flags, reqs;
  int          n_errors, check_count, cyc;
  int          bpos [4] = '{7, 5, 4, 3};
  pie_src src_u (.clk(clk), .rst(rst), .set_cmd(set_cmd), .clr_cmd(clr_cmd), .flags(flags));
  pie_top dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_fail_flag(flags[3]), .comparator_flag(flags[2]), .nvm_write_done_flag(flags[1]),
    .serial_bus_collision_flag(flags[0]), .clock_fail_req(reqs[3]), .comparator_req(reqs[2]),
    .nvm_write_done_req(reqs[1]), .serial_bus_collision_req(reqs[0]), .irq(irq));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge, so the next call never drives psel twice in one step
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("read data", rdat, exp);
  endtask : rd
  task automatic pulse(input logic clr, input logic [3:0] v);
    if (clr) clr_cmd <= v;
    else set_cmd <= v;
    @(posedge clk);
    clr_cmd <= 4'h0;
    set_cmd <= 4'h0;
    repeat (5) @(posedge clk);
  endtask : pulse
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // hang guard, whole run is well under this
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, set_cmd, clr_cmd} = '0;
    pstrb = 4'hf;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(pie_pkg::MASK_OFS, 32'h0);
    apb(1'b1, pie_pkg::MASK_OFS, 32'hff);
    rd(pie_pkg::MASK_OFS, 32'hb8);
    pstrb <= 4'h0;
    apb(1'b1, pie_pkg::MASK_OFS, 32'h0);
    pstrb <= 4'hf;
    apb(1'b1, 12'h010, 32'h0);
    chk("unmapped err", rerr, 1'b1);
    rd(12'h010, 32'h0);
    rd(pie_pkg::MASK_OFS, 32'hb8);
    rd(pie_pkg::STATUS_OFS, 32'h0);
    rd(pie_pkg::REQ_OFS, 32'h0);
    $display("test registers done");
    apb(1'b1, pie_pkg::IRQMASK_OFS, 32'hff);
    rd(pie_pkg::IRQMASK_OFS, 32'hb8);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, pie_pkg::MASK_OFS, 32'h0);
      pulse(1'b0, 4'h8 >> i);
      chk("req masked", reqs, 4'h0);
      apb(1'b1, pie_pkg::MASK_OFS, 32'h1 << bpos[i]);
      repeat (5) @(posedge clk);
      chk("req open", reqs, 4'h8 >> i);
      chk("flag kept", flags, 4'h8 >> i);
      chk("irq set", irq, 1'b1);
      rd(pie_pkg::STATUS_OFS, 32'h1 << bpos[i]);
      rd(pie_pkg::REQ_OFS, 32'h1 << bpos[i]);
      apb(1'b1, pie_pkg::MASK_OFS, 32'h0);
      repeat (3) @(posedge clk);
      chk("req closed", reqs, 4'h0);
      chk("flag after close", flags, 4'h8 >> i);
      apb(1'b1, pie_pkg::MASK_OFS, 32'h1 << bpos[i]);
      apb(1'b1, pie_pkg::IRQMASK_OFS, 32'h0);
      repeat (2) @(posedge clk);
      chk("irq masked", irq, 1'b0);
      apb(1'b1, pie_pkg::IRQMASK_OFS, 32'hb8);
      pulse(1'b1, 4'h8 >> i);
      chk("req gone", reqs, 4'h0);
      rd(pie_pkg::STATUS_OFS, 32'h1 << bpos[i]);
      apb(1'b1, pie_pkg::STATUS_OFS, 32'h1 << bpos[i]);
      repeat (2) @(posedge clk);
      chk("irq cleared", irq, 1'b0);
      rd(pie_pkg::STATUS_OFS, 32'h0);
    end
    $display("test sources done");
    test_done();
  end
endmodule : tb_pie_top
